// ---- core/bbd_regs.vh ----
// constants for the byte/bit instruction decoder: bus map, fields, codes
// assumes a 32-bit AHB-Lite bus with word-aligned register slots
`ifndef BBD_REGS_VH
`define BBD_REGS_VH
`define BBD_OFS_INSTR 8'h00
`define BBD_OFS_ACC 8'h04
`define BBD_OFS_BANK 8'h08
`define BBD_OFS_OPND 8'h0C
`define BBD_OFS_STATUS 8'h10
`define BBD_OFS_ADDR 8'h14
`define BBD_OFS_RESULT 8'h18
`define BBD_OFS_TARGET 8'h1C
`define BBD_OFS_CTRL 8'h20
`define BBD_OFS_PROD 8'h24
`define BBD_OFS_CFG 8'h28
`define BBD_FLG_C 0
`define BBD_FLG_DC 1
`define BBD_FLG_Z 2
`define BBD_FLG_OV 3
`define BBD_FLG_N 4
`define BBD_MASK_ALL 5'h1F
`define BBD_MASK_ZN 5'h14
`define BBD_MASK_CZN 5'h15
`define BBD_MASK_Z 5'h04
`define BBD_MASK_NONE 5'h00
`define BBD_ACCESS_BANK 4'h0
`define BBD_PREFIX2 4'hF
`define BBD_K_NOP 4'h0
`define BBD_K_BYTE 4'h1
`define BBD_K_BIT 4'h2
`define BBD_K_LIT 4'h3
`define BBD_K_MOVE 4'h4
`define BBD_K_JUMP 4'h5
`define BBD_K_CALL 4'h6
`define BBD_K_BRA 4'h7
`define BBD_K_BCOND 4'h8
`define BBD_K_RET 4'h9
`define BBD_K_SKIPPED 4'hA
`define BBD_K_OTHER 4'hB
`define BBD_W2_NONE 2'h0
`define BBD_W2_MOVE 2'h1
`define BBD_W2_JUMP 2'h2
`define BBD_W2_CALL 2'h3
`define BBD_CYC1 2'h1
`define BBD_CYC2 2'h2
`define BBD_CYC3 2'h3
`define BBD_HTRANS_NONSEQ 2'h2
`define BBD_HSIZE_WORD 3'h2
`endif

// ---- core/bbd_decoder.v ----
// instruction decoder with a small execute stage, reached over AHB-Lite
// assumes one master, word transfers, words fed in program order via INSTR
//
// Overview of operation
// - byte ops: low byte is file address; dest bit 0 accumulator, 1 file
// - bank bit 0 forces access bank, 1 lets bank selector pick the bank
// - register move spans two words, 12-bit source then 1111-prefixed dest
// - bit ops decode a 3-bit bit position, bank bit and address byte
// - literal ops take an 8-bit immediate from the low byte
// - jump and call build a 20-bit target: low byte, then 1111 word
// - call first word carries a fast-mode bit
// - unconditional branch uses an 11-bit signed offset in bits 10..0
// - conditional branches use an 8-bit signed offset; upper byte picks test
// - add and add-with-carry, one cycle, all five flags
// - OR, AND, XOR, complement update only zero and negative
// - compare-and-skip on less, equal, greater, zero; flags unchanged
// - decrement, increment with flags; four skip forms without flags
// - rotates through carry set C,Z,N; plain rotates Z,N; swap none
// - subtract forms set all flags; move register sets zero and negative
// - clear, set ones, negate, store accumulator, multiply
// - taken branch or true skip costs two cycles; skip over two words three
// - a lone second word executes as a no-operation
// - read-modify-write on the port reads the pin levels
// - write-back to the first timer count clears an assigned prescaler
// - fast bit saves shadows on call, restores them on return
`timescale 1ns/1ps
`include "bbd_regs.vh"
module bbd_decoder #(
  parameter [11:0] PORT_ADDR = 12'hF80,
  parameter [11:0] TIMER_ADDR = 12'hFD0
) (
  input wire sys_clk,
  input wire rst_b,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire [7:0] port_pins,
  output reg presc_clear
);
  // {ov, dc, c, sum}
  function [10:0] add8;
    input [7:0] x;
    input [7:0] y;
    input cin;
    reg [8:0] s;
    reg [4:0] h;
    begin
      s = {1'b0, x} + {1'b0, y} + {8'h00, cin};
      h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
      add8 = {(x[7] == y[7]) && (s[7] != x[7]), h[4], s[8], s[7:0]};
    end
  endfunction

  reg rst_meta, rst_n;
  reg [7:0] pin_s1, pin_s2;
  reg pend, pend_wr;
  reg [7:0] pend_ofs;
  reg [7:0] acc, bank, opnd;
  reg [4:0] flags;
  reg [7:0] sh_acc, sh_bank;
  reg [4:0] sh_flags;
  reg presc_assign;
  reg [1:0] wait2;
  reg skip_pend, skip_two;
  reg [7:0] lo8;
  reg [11:0] src_addr;
  reg [11:0] d_addr, d_dst;
  reg [7:0] d_res, d_lit;
  reg d_dest, d_wr, d_skip, d_fast, d_pins;
  reg [1:0] d_cyc;
  reg [4:0] d_mask;
  reg [19:0] d_tgt;
  reg [3:0] d_kind;
  reg [2:0] d_bit;
  reg [15:0] prod;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  wire [15:0] ir = hwdata[15:0];
  wire go = pend && pend_wr && (pend_ofs == `BBD_OFS_INSTR);
  wire is_second = (ir[15:12] == `BBD_PREFIX2);
  wire [3:0] eff_bank = ir[8] ? bank[3:0] : `BBD_ACCESS_BANK;
  wire [11:0] eff_addr = {eff_bank, ir[7:0]};
  wire [7:0] f_val = (eff_addr == PORT_ADDR) ? pin_s2 : opnd;
  wire two_word_first = (ir[15:12] == 4'hC) || (ir[15:9] == 7'h76) || (ir[15:8] == 8'hEF) || (ir[15:8] == 8'hEE);
  wire cond_flag = (ir[10:9] == 2'h0) ? flags[`BBD_FLG_Z] : (ir[10:9] == 2'h1) ? flags[`BBD_FLG_C] :
                   (ir[10:9] == 2'h2) ? flags[`BBD_FLG_OV] : flags[`BBD_FLG_N];
  wire br_taken = cond_flag ^ ir[8];

  reg [10:0] s;
  reg [7:0] res;
  reg [4:0] mask;
  reg nc, ndc, nov, wr, dst, skp, byte_op;
  always @* begin
    s = 11'h000;
    res = f_val;
    mask = `BBD_MASK_NONE;
    nc = flags[`BBD_FLG_C];
    ndc = flags[`BBD_FLG_DC];
    nov = flags[`BBD_FLG_OV];
    wr = 1'b1;
    dst = ir[9];
    skp = 1'b0;
    byte_op = 1'b1;
    case (ir[15:10])
      6'h09: begin s = add8(acc, f_val, 1'b0); mask = `BBD_MASK_ALL; end
      6'h08: begin s = add8(acc, f_val, flags[`BBD_FLG_C]); mask = `BBD_MASK_ALL; end
      6'h04: begin res = acc | f_val; mask = `BBD_MASK_ZN; end
      6'h05: begin res = acc & f_val; mask = `BBD_MASK_ZN; end
      6'h06: begin res = acc ^ f_val; mask = `BBD_MASK_ZN; end
      6'h07: begin res = ~f_val; mask = `BBD_MASK_ZN; end
      6'h01: begin s = add8(f_val, 8'hFF, 1'b0); mask = `BBD_MASK_ALL; end
      6'h0A: begin s = add8(f_val, 8'h00, 1'b1); mask = `BBD_MASK_ALL; end
      6'h0B: begin res = f_val - 8'h01; skp = (res == 8'h00); end
      6'h13: begin res = f_val - 8'h01; skp = (res != 8'h00); end
      6'h0F: begin res = f_val + 8'h01; skp = (res == 8'h00); end
      6'h12: begin res = f_val + 8'h01; skp = (res != 8'h00); end
      6'h0D: begin res = {f_val[6:0], flags[`BBD_FLG_C]}; nc = f_val[7]; mask = `BBD_MASK_CZN; end
      6'h0C: begin res = {flags[`BBD_FLG_C], f_val[7:1]}; nc = f_val[0]; mask = `BBD_MASK_CZN; end
      6'h11: begin res = {f_val[6:0], f_val[7]}; mask = `BBD_MASK_ZN; end
      6'h10: begin res = {f_val[0], f_val[7:1]}; mask = `BBD_MASK_ZN; end
      6'h0E: res = {f_val[3:0], f_val[7:4]};
      6'h17: begin s = add8(f_val, ~acc, 1'b1); mask = `BBD_MASK_ALL; end
      6'h16: begin s = add8(f_val, ~acc, flags[`BBD_FLG_C]); mask = `BBD_MASK_ALL; end
      6'h15: begin s = add8(acc, ~f_val, flags[`BBD_FLG_C]); mask = `BBD_MASK_ALL; end
      6'h14: mask = `BBD_MASK_ZN;
      6'h00: begin
        wr = 1'b0;
        byte_op = (ir[9] == 1'b1);
      end
      6'h18, 6'h19, 6'h1A, 6'h1B: begin
        dst = 1'b1;
        case (ir[11:9])
          3'h0: begin wr = 1'b0; skp = (f_val < acc); end
          3'h1: begin wr = 1'b0; skp = (f_val == acc); end
          3'h2: begin wr = 1'b0; skp = (f_val > acc); end
          3'h3: begin wr = 1'b0; skp = (f_val == 8'h00); end
          3'h4: res = 8'hFF;
          3'h5: begin res = 8'h00; mask = `BBD_MASK_Z; end
          3'h6: begin s = add8(8'h00, ~f_val, 1'b1); mask = `BBD_MASK_ALL; end
          default: res = acc;
        endcase
      end
      default: begin
        wr = 1'b0;
        byte_op = 1'b0;
      end
    endcase
    if (mask[`BBD_FLG_OV]) begin
      res = s[7:0];
      nc = s[8];
      ndc = s[9];
      nov = s[10];
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
    end else begin
      pin_s1 <= port_pins;
      pin_s2 <= pin_s1;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      pend <= 1'b0;
      pend_wr <= 1'b0;
      pend_ofs <= 8'h00;
    end else if (pend) begin
      pend <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      if (!pend_wr) begin
        case (pend_ofs)
          `BBD_OFS_ACC: hrdata <= {24'h000000, acc};
          `BBD_OFS_BANK: hrdata <= {24'h000000, bank};
          `BBD_OFS_OPND: hrdata <= {24'h000000, opnd};
          `BBD_OFS_STATUS: hrdata <= {27'h0000000, flags};
          `BBD_OFS_ADDR: hrdata <= {4'h0, d_dst, 4'h0, d_addr};
          `BBD_OFS_RESULT: hrdata <= {11'h000, d_mask, 2'h0, d_cyc, 1'b0, d_skip, d_wr, d_dest, d_res};
          `BBD_OFS_TARGET: hrdata <= {12'h000, d_tgt};
          `BBD_OFS_CTRL: hrdata <= {8'h00, d_lit, 3'h0, skip_pend, wait2, d_pins, d_fast, 1'b0, d_bit, d_kind};
          `BBD_OFS_PROD: hrdata <= {16'h0000, prod};
          `BBD_OFS_CFG: hrdata <= {31'h00000000, presc_assign};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end else if (hsel && hready && (htrans == `BBD_HTRANS_NONSEQ) && (hsize == `BBD_HSIZE_WORD)) begin
      pend <= 1'b1;
      pend_wr <= hwrite;
      pend_ofs <= haddr[7:0];
      hreadyout <= 1'b0;
      hrdata <= 32'h00000000;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 8'h00;
      bank <= 8'h00;
      opnd <= 8'h00;
      flags <= 5'h00;
      sh_acc <= 8'h00;
      sh_bank <= 8'h00;
      sh_flags <= 5'h00;
      presc_assign <= 1'b0;
      presc_clear <= 1'b0;
      wait2 <= `BBD_W2_NONE;
      skip_pend <= 1'b0;
      skip_two <= 1'b0;
      lo8 <= 8'h00;
      src_addr <= 12'h000;
      d_addr <= 12'h000;
      d_dst <= 12'h000;
      d_res <= 8'h00;
      d_lit <= 8'h00;
      d_dest <= 1'b0;
      d_wr <= 1'b0;
      d_skip <= 1'b0;
      d_fast <= 1'b0;
      d_pins <= 1'b0;
      d_cyc <= `BBD_CYC1;
      d_mask <= `BBD_MASK_NONE;
      d_tgt <= 20'h00000;
      d_kind <= `BBD_K_NOP;
      d_bit <= 3'h0;
      prod <= 16'h0000;
    end else begin
      presc_clear <= 1'b0;
      if (pend && pend_wr) begin
        case (pend_ofs)
          `BBD_OFS_ACC: acc <= hwdata[7:0];
          `BBD_OFS_BANK: bank <= {4'h0, hwdata[3:0]};
          `BBD_OFS_OPND: opnd <= hwdata[7:0];
          `BBD_OFS_STATUS: flags <= hwdata[4:0];
          `BBD_OFS_CFG: presc_assign <= hwdata[0];
          default: ;
        endcase
      end
      if (go) begin
        d_wr <= 1'b0;
        d_skip <= 1'b0;
        d_mask <= `BBD_MASK_NONE;
        d_cyc <= `BBD_CYC1;
        d_fast <= 1'b0;
        d_pins <= 1'b0;
        d_lit <= ir[7:0];
        d_bit <= ir[11:9];
        d_addr <= eff_addr;
        d_dst <= 12'h000;
        d_tgt <= 20'h00000;
        d_res <= 8'h00;
        d_dest <= 1'b0;
        wait2 <= `BBD_W2_NONE;
        skip_pend <= 1'b0;
        skip_two <= 1'b0;
        if (skip_two) begin
          d_kind <= `BBD_K_SKIPPED;
          d_cyc <= `BBD_CYC3;
        end else if (skip_pend) begin
          d_kind <= `BBD_K_SKIPPED;
          d_cyc <= two_word_first ? `BBD_CYC3 : `BBD_CYC2;
          skip_two <= two_word_first;
        end else if ((wait2 != `BBD_W2_NONE) && is_second) begin
          d_cyc <= `BBD_CYC2;
          if (wait2 == `BBD_W2_MOVE) begin
            d_kind <= `BBD_K_MOVE;
            d_addr <= src_addr;
            d_dst <= ir[11:0];
          end else begin
            d_kind <= (wait2 == `BBD_W2_CALL) ? `BBD_K_CALL : `BBD_K_JUMP;
            d_tgt <= {ir[11:0], lo8};
          end
        end else if (is_second) begin
          d_kind <= `BBD_K_NOP;
        end else if (ir[15:12] == 4'hC) begin
          d_kind <= `BBD_K_MOVE;
          src_addr <= ir[11:0];
          d_addr <= ir[11:0];
          wait2 <= `BBD_W2_MOVE;
        end else if ((ir[15:8] == 8'hEF) || (ir[15:9] == 7'h76)) begin
          lo8 <= ir[7:0];
          d_tgt <= {12'h000, ir[7:0]};
          d_kind <= ir[9] ? `BBD_K_JUMP : `BBD_K_CALL;
          wait2 <= ir[9] ? `BBD_W2_JUMP : `BBD_W2_CALL;
          d_fast <= ~ir[9] & ir[8];
          if (!ir[9] && ir[8]) begin
            sh_acc <= acc;
            sh_bank <= bank;
            sh_flags <= flags;
          end
        end else if (ir[15:12] == 4'hD) begin
          d_kind <= ir[11] ? `BBD_K_CALL : `BBD_K_BRA;
          d_tgt <= {{9{ir[10]}}, ir[10:0]};
          d_cyc <= `BBD_CYC2;
        end else if (ir[15:11] == 5'h1C) begin
          d_kind <= `BBD_K_BCOND;
          d_tgt <= {{12{ir[7]}}, ir[7:0]};
          d_skip <= br_taken;
          d_cyc <= br_taken ? `BBD_CYC2 : `BBD_CYC1;
        end else if ((ir[15:12] >= 4'h7) && (ir[15:12] <= 4'hB)) begin
          d_kind <= `BBD_K_BIT;
          d_pins <= (eff_addr == PORT_ADDR);
        end else if ((ir[15:12] == 4'h0) && ir[11]) begin
          d_kind <= `BBD_K_LIT;
        end else if ((ir[15:1] == 15'h0009) || (ir[15:1] == 15'h0008)) begin
          d_kind <= `BBD_K_RET;
          d_cyc <= `BBD_CYC2;
          d_fast <= ir[0];
          if (ir[0]) begin
            acc <= sh_acc;
            bank <= sh_bank;
            flags <= sh_flags;
          end
        end else if (byte_op) begin
          d_kind <= `BBD_K_BYTE;
          d_res <= res;
          d_dest <= dst;
          d_wr <= wr;
          d_mask <= mask;
          d_skip <= skp;
          d_pins <= (eff_addr == PORT_ADDR);
          d_cyc <= skp ? `BBD_CYC2 : `BBD_CYC1;
          skip_pend <= skp;
          if (ir[15:9] == 7'h01) begin
            prod <= acc * f_val;
          end
          if (wr && !dst) begin
            acc <= res;
          end
          if (wr && dst) begin
            opnd <= res;
          end
          if (wr && dst && (eff_addr == TIMER_ADDR) && presc_assign) begin
            presc_clear <= 1'b1;
          end
          flags <= {mask[`BBD_FLG_N] ? res[7] : flags[`BBD_FLG_N],
                    mask[`BBD_FLG_OV] ? nov : flags[`BBD_FLG_OV],
                    mask[`BBD_FLG_Z] ? (res == 8'h00) : flags[`BBD_FLG_Z],
                    mask[`BBD_FLG_DC] ? ndc : flags[`BBD_FLG_DC],
                    mask[`BBD_FLG_C] ? nc : flags[`BBD_FLG_C]};
        end else begin
          d_kind <= `BBD_K_OTHER;
        end
      end
    end
  end
endmodule // bbd_decoder

// ---- verification/bbd_decoder_sva.sv ----
// checker for the decoder's bus answers and prescaler pulse
// assumes one master, hready tied to hreadyout
`timescale 1ns/1ps
module bbd_decoder_sva (
  input wire sys_clk,
  input wire rst_b,
  input wire hsel,
  input wire [1:0] htrans,
  input wire [2:0] hsize,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire presc_clear
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  chk_one_wait: assert property (!hreadyout |=> hreadyout)
    else $error("wait longer than one cycle");
  chk_take_wait: assert property (hsel && hready && htrans == 2'h2 && hsize == 3'h2 |=> !hreadyout)
    else $error("no wait after taken transfer");
  chk_bad_size: assert property (hsel && htrans == 2'h2 && hsize != 3'h2 && hreadyout |=> hreadyout)
    else $error("wait on ignored size");
  chk_idle_nowait: assert property (hreadyout && !(hsel && htrans == 2'h2) |=> hreadyout)
    else $error("wait without transfer");
  chk_fall_cause: assert property ($fell(hreadyout) |-> $past(hsel && htrans == 2'h2, 1))
    else $error("wait without request");
  chk_wait_rdata: assert property (!hreadyout |-> hrdata == 32'h0)
    else $error("read data during wait");
  chk_presc_edge: assert property (presc_clear |-> $rose(hreadyout))
    else $error("prescaler clear off the data edge");
  chk_presc_pulse: assert property (presc_clear |=> !presc_clear)
    else $error("prescaler clear too long");
endmodule // bbd_decoder_sva
bind bbd_decoder bbd_decoder_sva bbd_decoder_sva_i (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .hsel(hsel),
  .htrans(htrans),
  .hsize(hsize),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .presc_clear(presc_clear)
);

// ---- verification/bbd_prog_mem.sv ----
// program memory model holding two-word move, jump and call sequences
// assumes the bench reads it combinationally by index
`timescale 1ns/1ps
module bbd_prog_mem (
  input wire [3:0] idx,
  output logic [15:0] word
);
  always_comb begin
    case (idx)
      4'h0: word = 16'hC5A3;
      4'h1: word = 16'hF2B4;
      4'h2: word = 16'hEF5C;
      4'h3: word = 16'hF9E1;
      4'h4: word = 16'hED11;
      default: word = 16'hF022;
    endcase
  end
endmodule // bbd_prog_mem

// ---- verification/tb_top.sv ----
// self-checking bench: feeds words over AHB-Lite and checks decode results
// assumes the decoder's register map and one wait state per bus transfer
`timescale 1ns/1ps
`include "bbd_regs.vh"
module tb_top;
  logic sys_clk = 0, rst_b = 0, hsel = 0, hwrite = 0, pc_seen = 0;
  logic [31:0] haddr = 0, hwdata = 0, r;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] port_pins = 0, av, fv;
  logic [8:0] e;
  logic [3:0] b, pidx = 0;
  logic [10:0] ko;
  logic k;
  logic sk;
  logic [7:0] op;
  logic [4:0] m, hc;
  wire hreadyout, hresp, presc_clear;
  wire [31:0] hrdata;
  wire [15:0] pword;
  int errors = 0, comparisons = 0, cyc = 0;
  always #25 sys_clk = ~sys_clk;
  bbd_decoder bbd_decoder_i (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .port_pins(port_pins),
    .presc_clear(presc_clear));
  bbd_prog_mem bbd_prog_mem_i (.idx(pidx), .word(pword));
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (presc_clear === 1'b1) pc_seen <= 1'b1;
    if (cyc == 8000) begin
      errors++;
      finish_test;
    end
  end
  task finish_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      errors++;
      $display("BAD %s exp %h got %h", n, x, s);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= `BBD_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task ex(input logic [15:0] w);
    xfer(1'b1, `BBD_OFS_INSTR, {16'h0, w});
  endtask
  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), r & m, x);
  endtask
  task feed(input logic [3:0] i);
    pidx = i;
    #1;
    ex(pword);
  endtask
  initial begin
    void'($urandom(76));
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      av = $urandom;
      fv = $urandom;
      b = $urandom;
      wr(`BBD_OFS_STATUS, 32'h1);
      wr(`BBD_OFS_ACC, av);
      wr(`BBD_OFS_OPND, fv);
      wr(`BBD_OFS_BANK, b);
      ex({5'b00100, ~i[2], i[1], i[0], 8'h33});
      e = av + fv + i[2];
      hc = av[3:0] + fv[3:0] + i[2];
      rc(`BBD_OFS_RESULT, 32'h1F01FF, {11'h0, 5'h1F, 7'h0, i[1], e[7:0]});
      rc(`BBD_OFS_STATUS, 32'h1F, {27'h0, e[7], (av[7] == fv[7]) && (e[7] != av[7]), ~|e[7:0], hc[4], e[8]});
      rc(`BBD_OFS_ADDR, 32'hFFF, {20'h0, i[0] ? b : 4'h0, 8'h33});
    end
    $display("add forms done");
    for (int j = 0; j < 4; j++) begin
      wr(`BBD_OFS_ACC, av);
      wr(`BBD_OFS_OPND, fv);
      ex({4'h1, j[1:0], 2'b00, 8'h44});
      e = j == 0 ? av | fv : j == 1 ? av & fv : j == 2 ? av ^ fv : ~fv;
      rc(`BBD_OFS_RESULT, 32'h1F00FF, {11'h0, 5'h14, 8'h0, e[7:0]});
    end
    $display("logic forms done");
    for (int c = 0; c < 8; c++) begin
      fv = c[1:0] == 2'h3 ? 8'h0 : av + $urandom % 3 - 1;
      wr(`BBD_OFS_ACC, av);
      wr(`BBD_OFS_OPND, fv);
      ex({4'h6, 1'b0, c[1:0], 1'b0, 8'h10});
      k = c[1:0] == 0 ? fv < av : c[1:0] == 1 ? fv == av : c[1:0] == 2 ? fv > av : fv == 8'h0;
      rc(`BBD_OFS_RESULT, 32'h3400, {18'h0, k ? 2'h2 : 2'h1, 1'b0, k, 10'h0});
      ex(16'hEF00);
      rc(`BBD_OFS_CTRL, 32'hF, k ? 32'hA : 32'h5);
      ex(16'hF000);
      rc(`BBD_OFS_RESULT, 32'h3000, k ? 32'h3000 : 32'h2000);
    end
    $display("skip forms done");
    feed(0);
    feed(1);
    rc(`BBD_OFS_ADDR, 32'h0FFF0FFF, 32'h02B405A3);
    feed(2);
    feed(3);
    rc(`BBD_OFS_TARGET, 32'hFFFFF, 32'h9E15C);
    feed(4);
    rc(`BBD_OFS_CTRL, 32'h10F, 32'h106);
    feed(5);
    rc(`BBD_OFS_TARGET, 32'hFFFFF, 32'h02211);
    wr(`BBD_OFS_ACC, {24'h0, ~av});
    ex(16'h0013);
    rc(`BBD_OFS_ACC, 32'hFF, av);
    wr(`BBD_OFS_ACC, {24'h0, ~av});
    ex(16'h0012);
    rc(`BBD_OFS_ACC, 32'hFF, {24'h0, ~av});
    ex(16'hF123);
    rc(`BBD_OFS_CTRL, 32'hF, 32'h0);
    ko = $urandom;
    ex({5'h1A, ko});
    rc(`BBD_OFS_TARGET, 32'hFFFFF, {{9{ko[10]}}, ko});
    ex({8'hE2, ko[7:0]});
    rc(`BBD_OFS_TARGET, 32'hFFFFF, {{12{ko[7]}}, ko[7:0]});
    ex(16'h9A21);
    rc(`BBD_OFS_CTRL, 32'h7F, 32'h52);
    ex(16'h0EA7);
    rc(`BBD_OFS_CTRL, 32'hFF000F, 32'hA70003);
    $display("formats done");
    for (int n = 0; n < 19; n++) begin
      av = $urandom;
      fv = $urandom;
      k = $urandom;
      sk = 1'b0;
      if (n == 2) fv = 8'h01;
      if (n == 4) fv = 8'hFF;
      case (n)
        0: begin op = 8'h06; m = 5'h1F; e = fv + 9'h0FF; end
        1: begin op = 8'h2A; m = 5'h1F; e = fv + 9'h001; end
        2: begin op = 8'h2E; m = 5'h00; e = fv - 8'h01; sk = e[7:0] == 8'h00; end
        3: begin op = 8'h4E; m = 5'h00; e = fv - 8'h01; sk = e[7:0] != 8'h00; end
        4: begin op = 8'h3E; m = 5'h00; e = fv + 8'h01; sk = e[7:0] == 8'h00; end
        5: begin op = 8'h4A; m = 5'h00; e = fv + 8'h01; sk = e[7:0] != 8'h00; end
        6: begin op = 8'h36; m = 5'h15; e = {fv, k}; end
        7: begin op = 8'h32; m = 5'h15; e = {fv[0], k, fv[7:1]}; end
        8: begin op = 8'h46; m = 5'h14; e = {1'b0, fv[6:0], fv[7]}; end
        9: begin op = 8'h42; m = 5'h14; e = {1'b0, fv[0], fv[7:1]}; end
        10: begin op = 8'h3A; m = 5'h00; e = {1'b0, fv[3:0], fv[7:4]}; end
        11: begin op = 8'h5E; m = 5'h1F; e = fv + {1'b0, ~av} + 9'h001; end
        12: begin op = 8'h5A; m = 5'h1F; e = fv + {1'b0, ~av} + k; end
        13: begin op = 8'h56; m = 5'h1F; e = av + {1'b0, ~fv} + k; end
        14: begin op = 8'h52; m = 5'h14; e = {1'b0, fv}; end
        15: begin op = 8'h68; m = 5'h00; e = 9'h0FF; end
        16: begin op = 8'h6A; m = 5'h04; e = 9'h000; end
        17: begin op = 8'h6C; m = 5'h1F; e = {1'b0, ~fv} + 9'h001; end
        default: begin op = 8'h6E; m = 5'h00; e = {1'b0, av}; end
      endcase
      wr(`BBD_OFS_STATUS, {31'h0, k});
      wr(`BBD_OFS_ACC, av);
      wr(`BBD_OFS_OPND, fv);
      ex({op, 8'h21});
      rc(`BBD_OFS_RESULT, 32'h1F04FF, {11'h0, m, 5'h0, sk, 2'h0, e[7:0]});
      rc(`BBD_OFS_STATUS, 32'h15, {27'h0, m[4] & e[7], 1'b0, m[2] & ~|e[7:0], 1'b0, m[0] ? e[8] : k});
      ex(16'h0000);
      rc(`BBD_OFS_CTRL, 32'hF, sk ? 32'hA : 32'hB);
    end
    wr(`BBD_OFS_OPND, fv);
    ex(16'h0221);
    rc(`BBD_OFS_PROD, 32'hFFFF, av * fv);
    $display("byte operations done");
    port_pins <= $urandom;
    wr(`BBD_OFS_BANK, 32'hF);
    ex(16'h5380);
    rc(`BBD_OFS_RESULT, 32'hFF, port_pins);
    wr(`BBD_OFS_CFG, 32'h1);
    pc_seen <= 1'b0;
    ex(16'h6BD0);
    @(posedge sys_clk);
    chk("prescaler on", pc_seen, 1);
    wr(`BBD_OFS_CFG, 32'h0);
    pc_seen <= 1'b0;
    ex(16'h6BD0);
    @(posedge sys_clk);
    chk("prescaler off", pc_seen, 0);
    rc(8'h30, 32'hFFFFFFFF, 32'h0);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= `BBD_HTRANS_NONSEQ;
    hsize <= 3'h0;
    @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hsize <= 3'h2;
    @(posedge sys_clk);
    chk("byte size ignored", hreadyout, 1);
    @(posedge sys_clk);
    $display("pins, prescaler and bus done");
    finish_test;
  end
endmodule // tb_top
